// ---- csdbs_pkg.sv ----
// Shared constants for the configuration-space bank-select block.
// Assumes a single 10 MHz core clock and byte-wide configuration cycles.
`default_nettype none

package csdbs_pkg;

    // Function banks and bank selection
    localparam int         NUM_FUNCS      = 8;
    localparam int         FUNC_W         = 3;
    localparam logic [7:0] FUNC_LIMIT     = 8'h08;

    // Global register indices
    localparam logic [7:0] IDX_LDN        = 8'h07;
    localparam logic [7:0] IDX_BASE_LO    = 8'h26;
    localparam logic [7:0] IDX_BASE_HI    = 8'h27;
    localparam logic [7:0] IDX_TEST_A     = 8'h2e;
    localparam logic [7:0] IDX_TEST_B     = 8'h2f;

    // Per-function bank indices
    localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
    localparam logic [7:0] IDX_RSV_LO     = 8'h31;
    localparam logic [7:0] IDX_RSV_HI     = 8'h5f;

    // Field positions and reset values
    localparam int         ACT_BIT        = 0;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [7:0] READ_ZERO      = 8'h00;
    localparam logic [15:0] CFG_BASE_RESET = 16'h002e;

    // Reserved control, vendor control and memory-base ranges
    function automatic logic is_reserved(input logic [7:0] idx);
        return (idx >= IDX_RSV_LO) && (idx <= IDX_RSV_HI);
    endfunction

endpackage

`default_nettype wire

// ---- csdbs_if.sv ----
// Carrier between the configuration core, port decoder and activate bank.
// Assumes all three sit in the core clock domain.
`default_nettype none

interface csdbs_if import csdbs_pkg::*;;
    logic                 idx_hit;
    logic                 data_hit;
    logic                 act_wr;
    logic [FUNC_W-1:0]    act_func;
    logic                 act_val;
    logic                 pwr_wr;
    logic [FUNC_W-1:0]    pwr_func;
    logic                 pwr_val;
    logic                 act_clr;
    logic [NUM_FUNCS-1:0] act_bits;

    modport dec  (output idx_hit, data_hit);
    modport bank (input  act_wr, act_func, act_val, pwr_wr, pwr_func,
                         pwr_val, act_clr,
                  output act_bits);
    modport core (input  idx_hit, data_hit, act_bits,
                  output act_wr, act_func, act_val, pwr_wr, pwr_func,
                         pwr_val, act_clr);
endinterface

`default_nettype wire

// ---- csdbs_port_decode.sv ----
// Decodes host cycles onto the index and data ports.
// Assumes the base address is even; data port sits one above it.
`default_nettype none

module csdbs_port_decode
    import csdbs_pkg::*;
(
    input  wire logic [15:0] io_addr,    // Host cycle address
    input  wire logic [15:0] cfg_base,   // Current configuration base
    input  wire logic        cfg_active, // Configuration state
    csdbs_if.dec             cif         // Decode results
);

    // Whole port is dark outside configuration state
    assign cif.idx_hit  = cfg_active && (io_addr == cfg_base);
    assign cif.data_hit = cfg_active &&
                          (io_addr == {cfg_base[15:1], 1'b1});

endmodule

`default_nettype wire

// ---- csdbs_activate_bank.sv ----
// One activate bit per function, shared with its power-control bit.
// Assumes write requests are single-cycle pulses from the core.
`default_nettype none

module csdbs_activate_bank
    import csdbs_pkg::*;
(
    input  wire logic core_clk, // Core clock
    input  wire logic rst_n,    // Async reset, active low
    csdbs_if.bank     bif       // Bank requests and state
);

    // One flop serves both bits, so they can never disagree
    genvar i;
    generate
        for (i = 0; i < NUM_FUNCS; i++) begin : g_func
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    bif.act_bits[i] <= 1'b0;
                end else if (bif.act_clr) begin
                    bif.act_bits[i] <= 1'b0;
                end else if (bif.pwr_wr &&
                             bif.pwr_func == FUNC_W'(i)) begin
                    bif.act_bits[i] <= bif.pwr_val;
                end else if (bif.act_wr &&
                             bif.act_func == FUNC_W'(i)) begin
                    bif.act_bits[i] <= bif.act_val;
                end
            end
        end
    endgenerate

    act_set_a: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        bif.act_wr && !bif.act_clr && !bif.pwr_wr
        |=> bif.act_bits[$past(bif.act_func)] == $past(bif.act_val))
        else $error("activate write not applied to selected function");

    act_clear_a: assert property (@(posedge core_clk)
        disable iff (!rst_n) bif.act_clr |=> bif.act_bits == '0)
        else $error("activate bits not cleared by reset event");

    link_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        bif.pwr_wr && !bif.act_clr
        |=> bif.act_bits[$past(bif.pwr_func)] == $past(bif.pwr_val))
        else $error("power-control change did not follow to activate");

endmodule

`default_nettype wire

// ---- csdbs_config_space.sv ----
// Configuration space: index/data ports, relocatable base, bank select.
// Assumes synchronous host strobes, one cycle each, on core_clk.
//
// How it works
// - New base takes effect on the next edge after the high byte write.
// - Low byte is only staged; writing the high byte applies both.
// - Bank-number register picks which function's bank is visible.
// - Index port selects a register; data port reads or writes it.
// - Index and data ports respond only in configuration state.
// - Activate bit 0 turns the selected function on or off.
// - Activate bits clear on power-on, standby, hard and soft reset.
// - Function is on whenever its activate or power-control bit is set.
// - Activate and power-control bits are one shared bit per function.
// - Reserved bank offsets ignore writes and read back zero.
// - Test registers clear on both power-on resets; hard and soft reset leave them.
`default_nettype none

module csdbs_config_space
    import csdbs_pkg::*;
(
    input  wire logic                 core_clk,      // 10 MHz core clock
    input  wire logic                 rst_n,         // Main supply POR
    input  wire logic                 standby_supply_power_on_reset, // Pulse
    input  wire logic                 hard_reset,    // Hard reset pulse
    input  wire logic                 soft_reset,    // Soft reset pulse
    input  wire logic                 config_state_active, // Cfg state
    input  wire logic [15:0]          io_addr,       // Host cycle address
    input  wire logic                 io_wr,         // Host write strobe
    input  wire logic                 io_rd,         // Host read strobe
    input  wire logic [7:0]           io_wdata,      // Host write data
    output logic      [7:0]           io_rdata,      // Read data
    output logic                      io_rvalid,     // Read data valid
    input  wire logic                 pwr_ctl_wr,    // Power-bit write
    input  wire logic [FUNC_W-1:0]    pwr_ctl_func,  // Power-bit function
    input  wire logic                 pwr_ctl_val,   // Power-bit value
    output logic      [NUM_FUNCS-1:0] func_active,   // Function on
    output logic      [15:0]          cfg_base_addr  // Current base
);

    csdbs_if cif ();

    logic [7:0]  index_reg;
    logic [7:0]  ldn_reg;
    logic [7:0]  base_lo_reg;
    logic [15:0] base_reg;
    logic [7:0]  test_a_reg;
    logic [7:0]  test_b_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rvalid_reg;
    logic        wr_idx;
    logic        wr_data;
    logic        rd_hit;
    logic        por_clr;
    logic        ldn_ok;

    csdbs_port_decode u_decode (
        .io_addr    (io_addr),
        .cfg_base   (base_reg),
        .cfg_active (config_state_active),
        .cif        (cif.dec)
    );

    csdbs_activate_bank u_bank (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .bif      (cif.bank)
    );

    assign wr_idx  = io_wr && cif.idx_hit;
    assign wr_data = io_wr && cif.data_hit;
    assign rd_hit  = io_rd && (cif.idx_hit || cif.data_hit);
    assign por_clr = standby_supply_power_on_reset;
    // Bank numbers beyond the implemented functions see an empty bank
    assign ldn_ok  = ldn_reg < FUNC_LIMIT;

    // Index register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_reg <= REG_RESET;
        end else if (por_clr) begin
            index_reg <= REG_RESET;
        end else if (wr_idx) begin
            index_reg <= io_wdata;
        end
    end

    // Bank number register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ldn_reg <= REG_RESET;
        end else if (por_clr) begin
            ldn_reg <= REG_RESET;
        end else if (wr_data && index_reg == IDX_LDN) begin
            ldn_reg <= io_wdata;
        end
    end

    // Low base byte is staged so the port never sits half-moved
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_lo_reg <= CFG_BASE_RESET[7:0];
        end else if (por_clr) begin
            base_lo_reg <= CFG_BASE_RESET[7:0];
        end else if (wr_data && index_reg == IDX_BASE_LO) begin
            base_lo_reg <= {io_wdata[7:1], 1'b0};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_reg <= CFG_BASE_RESET;
        end else if (por_clr) begin
            base_reg <= CFG_BASE_RESET;
        end else if (wr_data && index_reg == IDX_BASE_HI) begin
            base_reg <= {io_wdata, base_lo_reg};
        end
    end

    // Test registers survive hard and soft reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_a_reg <= REG_RESET;
            test_b_reg <= REG_RESET;
        end else if (por_clr) begin
            test_a_reg <= REG_RESET;
            test_b_reg <= REG_RESET;
        end else if (wr_data && index_reg == IDX_TEST_A) begin
            test_a_reg <= io_wdata;
        end else if (wr_data && index_reg == IDX_TEST_B) begin
            test_b_reg <= io_wdata;
        end
    end

    // Bank requests; upper activate bits are simply not stored
    assign cif.act_wr   = wr_data && index_reg == IDX_ACTIVATE &&
                          ldn_ok;
    assign cif.act_func = ldn_reg[FUNC_W-1:0];
    assign cif.act_val  = io_wdata[ACT_BIT];
    assign cif.pwr_wr   = pwr_ctl_wr;
    assign cif.pwr_func = pwr_ctl_func;
    assign cif.pwr_val  = pwr_ctl_val;
    assign cif.act_clr  = por_clr || hard_reset || soft_reset;

    // Read path
    always_comb begin
        rdata_next = READ_ZERO;
        if (cif.idx_hit) begin
            rdata_next = index_reg;
        end else if (is_reserved(index_reg)) begin
            rdata_next = READ_ZERO;
        end else begin
            case (index_reg)
                IDX_LDN: begin
                    rdata_next = ldn_reg;
                end
                IDX_BASE_LO: begin
                    rdata_next = base_lo_reg;
                end
                IDX_BASE_HI: begin
                    rdata_next = base_reg[15:8];
                end
                IDX_TEST_A: begin
                    rdata_next = test_a_reg;
                end
                IDX_TEST_B: begin
                    rdata_next = test_b_reg;
                end
                IDX_ACTIVATE: begin
                    if (ldn_ok) begin
                        rdata_next[ACT_BIT] =
                            cif.act_bits[ldn_reg[FUNC_W-1:0]];
                    end
                end
                default: begin
                    rdata_next = READ_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= READ_ZERO;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= rd_hit;
            if (rd_hit) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign io_rdata      = rdata_reg;
    assign io_rvalid     = rvalid_reg;
    // Shared bit means activate-or-power reduces to the bit itself
    assign func_active   = cif.act_bits;
    assign cfg_base_addr = base_reg;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    idx_write_a: assert property (
        wr_idx && !por_clr |=> index_reg == $past(io_wdata))
        else $error("index port write not captured");

    base_move_a: assert property (
        wr_data && index_reg == IDX_BASE_HI && !por_clr
        |=> cfg_base_addr == {$past(io_wdata), $past(base_lo_reg)})
        else $error("base did not move on high byte write");

    base_hold_a: assert property (
        wr_data && index_reg == IDX_BASE_LO && !por_clr
        |=> $stable(cfg_base_addr)
            && base_lo_reg == {$past(io_wdata[7:1]), 1'b0})
        else $error("low byte write moved base or was not staged");

    base_even_a: assert property (
        cfg_base_addr[0] == 1'b0)
        else $error("configuration base is odd");

    bank_read_a: assert property (
        rd_hit && cif.data_hit && index_reg == IDX_ACTIVATE && ldn_ok
        |=> io_rvalid && io_rdata[7:1] == 7'h00
            && io_rdata[ACT_BIT] ==
               $past(cif.act_bits[ldn_reg[FUNC_W-1:0]]))
        else $error("activate readback not from selected bank");

    cfg_gate_a: assert property (
        io_rd && !config_state_active |=> !io_rvalid)
        else $error("read answered outside configuration state");

    no_write_a: assert property (
        io_wr && !config_state_active && !pwr_ctl_wr && !cif.act_clr
        |=> $stable(func_active) && $stable(ldn_reg) && $stable(index_reg))
        else $error("bank changed by write outside configuration state");

    reserved_a: assert property (
        rd_hit && cif.data_hit && is_reserved(index_reg)
        |=> io_rdata == READ_ZERO)
        else $error("reserved offset read not zero");

    test_reset_a: assert property (
        por_clr |=> test_a_reg == REG_RESET && test_b_reg == REG_RESET)
        else $error("test registers not cleared by standby reset");

    power_on_a: assert property (
        pwr_ctl_wr && !cif.act_clr
        |=> func_active[$past(pwr_ctl_func)] == $past(pwr_ctl_val))
        else $error("function state does not follow power-control bit");

    base_move_c: cover property (
        wr_data && index_reg == IDX_BASE_HI ##2 cif.idx_hit);
    act_set_c: cover property (
        cif.act_wr && cif.act_val ##1 func_active != '0);
    reserved_c: cover property (
        rd_hit && cif.data_hit && is_reserved(index_reg));
    pwr_link_c: cover property (
        pwr_ctl_wr && pwr_ctl_val ##4 rd_hit && index_reg == IDX_ACTIVATE);

endmodule

`default_nettype wire

// ---- csdbs_host_model.sv ----
// Host bus controller model issuing index/data configuration cycles.
// Assumes one-cycle strobes sampled on the rising core clock edge.
`default_nettype none

module csdbs_host_model
    import csdbs_pkg::*;
(
    input  wire logic        core_clk, // Core clock
    output logic      [15:0] io_addr,  // Cycle address
    output logic             io_wr,    // Write strobe
    output logic             io_rd,    // Read strobe
    output logic      [7:0]  io_wdata  // Write data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] base;

    initial begin
        base     = CFG_BASE_RESET;
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // One strobe cycle; released lines invert so no stale value lingers
    task automatic raw(input logic [15:0] a, input logic wr,
                       input logic [7:0] d);
        @(posedge core_clk);
        io_addr  <= a;
        io_wr    <= wr;
        io_rd    <= ~wr;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr    <= 1'b0;
        io_rd    <= 1'b0;
        io_addr  <= ~a;
        io_wdata <= ~d;
    endtask

    // Index first, then data port
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        raw(base, 1'b1, idx);
        raw(base | 16'h0001, 1'b1, d);
    endtask

    task automatic reg_rd(input logic [7:0] idx);
        raw(base, 1'b1, idx);
        raw(base | 16'h0001, 1'b0, 8'h00);
    endtask

    // Low byte before high byte, bit zero kept clear
    task automatic relocate(input logic [15:0] nb);
        reg_wr(IDX_BASE_LO, {nb[7:1], 1'b0});
        reg_wr(IDX_BASE_HI, nb[15:8]);
        base = {nb[15:1], 1'b0};
    endtask
endmodule

`default_nettype wire

// ---- csdbs_config_space_tb.sv ----
// Self-checking bench for the configuration-space bank-select block.
// Assumes the host model drives the ports; reads scored from a queue.
`default_nettype none

module csdbs_config_space_tb
    import csdbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 core_clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 sby_por = 1'b0;
    logic                 hard_reset = 1'b0;
    logic                 soft_reset = 1'b0;
    logic                 cfg_on = 1'b1;
    logic [15:0]          io_addr;
    logic                 io_wr;
    logic                 io_rd;
    logic [7:0]           io_wdata;
    logic [7:0]           io_rdata;
    logic                 io_rvalid;
    logic                 pwr_wr = 1'b0;
    logic [FUNC_W-1:0]    pwr_func = '0;
    logic                 pwr_val = 1'b0;
    logic [NUM_FUNCS-1:0] func_active;
    logic [15:0]          cfg_base_addr;
    logic [7:0]           exp_q[$];
    logic [7:0]           exp_act;
    logic [7:0]           e;
    logic [2:0]           r;
    int                   err_count = 0;
    int                   check_count = 0;
    int                   i;
    int unsigned          seed;

    always #50 core_clk = ~core_clk;

    csdbs_config_space u_csdbs_config_space (
        .core_clk                      (core_clk),
        .rst_n                         (rst_n),
        .standby_supply_power_on_reset (sby_por),
        .hard_reset                    (hard_reset),
        .soft_reset                    (soft_reset),
        .config_state_active           (cfg_on),
        .io_addr                       (io_addr),
        .io_wr                         (io_wr),
        .io_rd                         (io_rd),
        .io_wdata                      (io_wdata),
        .io_rdata                      (io_rdata),
        .io_rvalid                     (io_rvalid),
        .pwr_ctl_wr                    (pwr_wr),
        .pwr_ctl_func                  (pwr_func),
        .pwr_ctl_val                   (pwr_val),
        .func_active                   (func_active),
        .cfg_base_addr                 (cfg_base_addr)
    );

    csdbs_host_model u_csdbs_host_model (
        .core_clk (core_clk),
        .io_addr  (io_addr),
        .io_wr    (io_wr),
        .io_rd    (io_rd),
        .io_wdata (io_wdata)
    );

    task automatic mism(input string msg);
        err_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        check_count++;
        if (got !== exp) begin
            mism(msg);
        end
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        exp_q.push_back(exp);
        u_csdbs_host_model.reg_rd(idx);
    endtask

    // Pulse a side input for one edge, then look after it lands
    task automatic pulse(input int                which,
                         input logic [FUNC_W-1:0] f = '0,
                         input logic              v = 1'b0);
        @(posedge core_clk);
        case (which)
            0: hard_reset <= 1'b1;
            1: soft_reset <= 1'b1;
            2: sby_por <= 1'b1;
            default: begin
                pwr_wr   <= 1'b1;
                pwr_func <= f;
                pwr_val  <= v;
            end
        endcase
        @(posedge core_clk);
        hard_reset <= 1'b0;
        soft_reset <= 1'b0;
        sby_por    <= 1'b0;
        pwr_wr     <= 1'b0;
        @(negedge core_clk);
    endtask

    always @(negedge core_clk) begin
        if (io_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mism("read answered while none was expected");
            end else begin
                e = exp_q.pop_front();
                check_count++;
                if (io_rdata !== e) begin
                    mism("read data differs");
                end
            end
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0 && exp_q.size() == 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        mism("watchdog expired");
        end_of_test();
    end

    initial begin
        seed = $urandom(16);
        exp_act = 8'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(cfg_base_addr, CFG_BASE_RESET, "base reset value");
        chk({8'h00, func_active}, 16'h0000, "functions after reset");
        rd_chk(IDX_TEST_A, 8'h00);
        rd_chk(IDX_TEST_B, 8'h00);
        $display("test reset_values done");
        r = 3'($urandom());
        for (i = 0; i < NUM_FUNCS; i++) begin
            u_csdbs_host_model.reg_wr(IDX_LDN, {5'h00, 3'(i) ^ r});
            u_csdbs_host_model.reg_wr(IDX_ACTIVATE, 8'h01);
            @(negedge core_clk);
            exp_act[3'(i) ^ r] = 1'b1;
            chk({8'h00, func_active}, {8'h00, exp_act}, "activate");
            rd_chk(IDX_ACTIVATE, 8'h01);
        end
        // Bank number past the last function: empty bank, writes dropped
        u_csdbs_host_model.reg_wr(IDX_LDN, FUNC_LIMIT);
        u_csdbs_host_model.reg_wr(IDX_ACTIVATE, 8'h00);
        rd_chk(IDX_ACTIVATE, 8'h00);
        u_csdbs_host_model.reg_wr(IDX_LDN, 8'h03);
        u_csdbs_host_model.reg_wr(IDX_ACTIVATE, 8'h00);
        @(negedge core_clk);
        exp_act[3] = 1'b0;
        chk({8'h00, func_active}, {8'h00, exp_act}, "deactivate");
        $display("test activate done");
        for (i = 'h31; i <= 'h5f; i++) begin
            u_csdbs_host_model.reg_wr(8'(i), 8'($urandom()));
            rd_chk(8'(i), 8'h00);
        end
        @(negedge core_clk);
        chk({8'h00, func_active}, {8'h00, exp_act}, "reserved write");
        $display("test reserved done");
        pulse(3, 3'h3, 1'b1);
        exp_act[3] = 1'b1;
        chk({8'h00, func_active}, {8'h00, exp_act}, "power bit on");
        rd_chk(IDX_ACTIVATE, 8'h01);
        pulse(3, 3'h3, 1'b0);
        exp_act[3] = 1'b0;
        rd_chk(IDX_ACTIVATE, 8'h00);
        $display("test power_link done");
        @(posedge core_clk);
        cfg_on <= 1'b0;
        u_csdbs_host_model.reg_wr(IDX_ACTIVATE, 8'h01);
        u_csdbs_host_model.reg_rd(IDX_ACTIVATE);
        @(negedge core_clk);
        chk({8'h00, func_active}, {8'h00, exp_act}, "write outside");
        @(posedge core_clk);
        cfg_on <= 1'b1;
        $display("test config_state done");
        u_csdbs_host_model.reg_wr(IDX_BASE_LO, 8'h4e);
        @(negedge core_clk);
        chk(cfg_base_addr, CFG_BASE_RESET, "low byte alone");
        u_csdbs_host_model.reg_wr(IDX_BASE_HI, 8'h03);
        u_csdbs_host_model.base = 16'h034e;
        @(negedge core_clk);
        chk(cfg_base_addr, 16'h034e, "relocated base");
        rd_chk(IDX_LDN, 8'h03);
        rd_chk(IDX_BASE_HI, 8'h03);
        rd_chk(IDX_BASE_LO, 8'h4e);
        exp_q.push_back(IDX_BASE_LO);
        u_csdbs_host_model.raw(16'h034e, 1'b0, 8'h00);
        u_csdbs_host_model.raw(16'h002e, 1'b1, IDX_ACTIVATE);
        u_csdbs_host_model.raw(16'h002f, 1'b1, 8'h01);
        u_csdbs_host_model.raw(16'h002f, 1'b0, 8'h00);
        @(negedge core_clk);
        chk({8'h00, func_active}, {8'h00, exp_act}, "old base");
        $display("test relocate done");
        for (i = 0; i < 3; i++) begin
            pulse(3, 3'(i + 5), 1'b1);
            pulse(i);
            exp_act = 8'h00;
            chk({8'h00, func_active}, 16'h0000, "reset pulse");
        end
        u_csdbs_host_model.base = CFG_BASE_RESET;
        chk(cfg_base_addr, CFG_BASE_RESET, "base after standby");
        rd_chk(IDX_TEST_A, 8'h00);
        $display("test reset_pulses done");
        repeat (3) @(negedge core_clk);
        end_of_test();
    end
endmodule

`default_nettype wire
